// >>> vsp_consts.svh
`ifndef VSP_CONSTS_SVH
`define VSP_CONSTS_SVH

// ==========================================================
// Register offsets
`define VSP_OFS_CTRL        8'h00
`define VSP_OFS_ADDR        8'h04
`define VSP_OFS_CFG         8'h08
`define VSP_OFS_STATUS      8'h0c

// ==========================================================
// Field positions
`define VSP_CTRL_GO         0
`define VSP_CTRL_CMD_LSB    1
`define VSP_CTRL_AUTO_SP    4
`define VSP_ADDR_ROW_LSB    0
`define VSP_ADDR_COL_LSB    16
`define VSP_CFG_PLEN_LSB    0
`define VSP_CFG_SCNT_LSB    8
`define VSP_ST_BUSY         0
`define VSP_ST_INIT_DONE    1
`define VSP_ST_FULL_DONE    2
`define VSP_ST_STOP_MODE    3
`define VSP_ST_HALF_FLAG    4
`define VSP_ST_REFUSED      5

// ==========================================================
// Reset values
`define VSP_RST_ADDR        32'h0000_0000
`define VSP_RST_CFG         32'h0000_0303

// ==========================================================
// Timing
`define VSP_CLK_NS          4
`define VSP_PAUSE_US        200
`define VSP_T_RP_NS         60
`define VSP_T_RAS_NS        80
`define VSP_T_RCD_NS        20
`define VSP_T_SS_HALF_NS    15
`define VSP_INIT_RAS_CYCLES 8
`define VSP_INIT_SS_CYCLES  2
`define VSP_CEIL_CYC(ns)    (((ns) + `VSP_CLK_NS - 1) / `VSP_CLK_NS)
`define VSP_PAUSE_CYC       ((`VSP_PAUSE_US * 1000) / `VSP_CLK_NS)
`define VSP_T_RP_CYC        `VSP_CEIL_CYC(`VSP_T_RP_NS)
`define VSP_T_RAS_CYC       `VSP_CEIL_CYC(`VSP_T_RAS_NS)
`define VSP_T_RCD_CYC       `VSP_CEIL_CYC(`VSP_T_RCD_NS)
`define VSP_T_SS_HALF_CYC   `VSP_CEIL_CYC(`VSP_T_SS_HALF_NS)

`endif

// >>> vsp_pkg.sv
package vsp_pkg;

  typedef enum logic [2:0] {
    VSP_CMD_INIT, VSP_CMD_FULL, VSP_CMD_SPLIT, VSP_CMD_SPST, VSP_CMD_ORS, VSP_CMD_SERIAL
  } vsp_cmd_t;

  typedef enum logic [2:0] {
    VSP_K_REF, VSP_K_FULL, VSP_K_SPLIT, VSP_K_SPST, VSP_K_ORS
  } vsp_kind_t;

  typedef enum {
    VSP_ST_IDLE, VSP_ST_PAUSE, VSP_ST_PRE, VSP_ST_RAS, VSP_ST_SCH, VSP_ST_SCL
  } vsp_state_t;

  typedef enum {
    VSP_SEQ_SINGLE, VSP_SEQ_INIT_REF, VSP_SEQ_INIT_XFER, VSP_SEQ_INIT_SS
  } vsp_seq_t;

endpackage

// >>> vsp_sync.sv
`timescale 1ns/1ns
module vsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // ==========================================================
  // Two-flop synchroniser per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic sync_reg;
      logic sync_next;
      always_comb begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (ce) begin
          meta_next = d[i];
          sync_next = meta_reg;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate
endmodule

// >>> vsp_ctrl.sv
// How it works
// - Serial clocking never overlaps a transfer cycle.
// - Stop-point set: CAS low, WE low, special function high at RAS fall.
// - Option-reset refresh cycle ends stop-point mode.
// - Issue stop-point set right after power-up initialization.
// - Wait 200 us, then eight RAS cycles before using the array.
// - Serial port init: one full transfer then two serial clocks.
// - Full transfer must precede the first split transfer.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "vsp_consts.svh"
module vsp_ctrl #(
  parameter int PAUSE_CYCLES = `VSP_PAUSE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             ras_n,
  output logic             cas_n,
  output logic             write_enable_n,
  output logic             transfer_gate_n,
  output logic             special_function_select,
  output logic [8:0]       addr,
  output logic             serial_shift_strobe,
  input  wire logic        half_select_flag
);
  import vsp_pkg::*;

  localparam int CNT_W = 17;

  // ==========================================================
  // Register file and AXI4-Lite slave
  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [31:0] addr_cfg_reg, addr_cfg_next, cfg_reg, cfg_next;
  logic        auto_sp_reg, auto_sp_next;
  logic        go;
  vsp_cmd_t    go_cmd;
  logic        refuse_clr;
  logic        flag_sync;
  logic [31:0] status;
  logic        busy;

  vsp_sync #(.WIDTH(1)) u_flag_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (half_select_flag),
    .q       (flag_sync)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  always_comb begin
    awready_next  = awready_reg;
    wready_next   = wready_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    arready_next  = arready_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    addr_cfg_next = addr_cfg_reg;
    cfg_next      = cfg_reg;
    auto_sp_next  = auto_sp_reg;
    go            = 1'b0;
    go_cmd        = vsp_cmd_t'(s_axi_wdata[`VSP_CTRL_CMD_LSB +: 3]);
    refuse_clr    = 1'b0;
    if (awready_reg && s_axi_awvalid) begin
      awready_next = 1'b0;
      awaddr_next  = s_axi_awaddr;
    end
    if (wready_reg && s_axi_wvalid) begin
      wready_next = 1'b0;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    // Both halves held: perform the write once
    if (!awready_reg && !wready_reg && !bvalid_reg) begin
      bvalid_next = 1'b1;
      bresp_next  = 2'b00;
      go_cmd      = vsp_cmd_t'(wdata_reg[`VSP_CTRL_CMD_LSB +: 3]);
      case (awaddr_reg)
        `VSP_OFS_CTRL: begin
          if (wstrb_reg[0]) begin
            auto_sp_next = wdata_reg[`VSP_CTRL_AUTO_SP];
            go           = wdata_reg[`VSP_CTRL_GO];
          end
        end
        `VSP_OFS_ADDR: addr_cfg_next = merge(addr_cfg_reg, wdata_reg, wstrb_reg);
        `VSP_OFS_CFG: cfg_next = merge(cfg_reg, wdata_reg, wstrb_reg);
        `VSP_OFS_STATUS: refuse_clr = wstrb_reg[0] && wdata_reg[`VSP_ST_REFUSED];
        default: bresp_next = 2'b10;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    if (arready_reg && s_axi_arvalid) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = 2'b00;
      case (s_axi_araddr)
        `VSP_OFS_CTRL: rdata_next = {27'h0, auto_sp_reg, 4'h0};
        `VSP_OFS_ADDR: rdata_next = addr_cfg_reg;
        `VSP_OFS_CFG: rdata_next = cfg_reg;
        `VSP_OFS_STATUS: rdata_next = status;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = 2'b10;
        end
      endcase
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= 2'b00;
      arready_reg  <= 1'b1;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= 2'b00;
      rdata_reg    <= 32'h0000_0000;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      addr_cfg_reg <= `VSP_RST_ADDR;
      cfg_reg      <= `VSP_RST_CFG;
      auto_sp_reg  <= 1'b0;
    end else if (ce) begin
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      addr_cfg_reg <= addr_cfg_next;
      cfg_reg      <= cfg_next;
      auto_sp_reg  <= auto_sp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // ==========================================================
  // Pin sequencer
  vsp_state_t state_reg, state_next;
  vsp_kind_t  kind_reg, kind_next;
  vsp_seq_t   seq_reg, seq_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] ref_cnt_reg, ref_cnt_next;
  logic [8:0] ss_left_reg, ss_left_next;
  logic       ras_reg, ras_next, cas_reg, cas_next, we_reg, we_next, tgn_reg, tgn_next;
  logic       sfs_reg, sfs_next, ss_reg, ss_next;
  logic [8:0] addr_reg, addr_next;
  logic       init_done_reg, init_done_next, full_done_reg, full_done_next;
  logic       stop_mode_reg, stop_mode_next, refused_reg, refused_next;
  logic       refuse_set;
  logic [8:0] col, col_pins;

  assign busy = (state_reg != VSP_ST_IDLE);
  assign col  = addr_cfg_reg[`VSP_ADDR_COL_LSB +: 9];
  assign status = {26'h0, refused_reg, flag_sync, stop_mode_reg,
                   full_done_reg, init_done_reg, busy};

  // Partition length code onto A7..A4
  function automatic logic [3:0] plen_code(input logic [1:0] sel);
    case (sel)
      2'd0:    plen_code = 4'b0000;
      2'd1:    plen_code = 4'b0001;
      2'd2:    plen_code = 4'b0011;
      default: plen_code = 4'b0111;
    endcase
  endfunction

  // Logical bit 8 rides on pin 7 and vice versa while stop points are on;
  // a split leaves the half choice to the device.
  always_comb begin
    col_pins = col;
    if (kind_reg == VSP_K_SPLIT) col_pins[7] = 1'b0;
    if (stop_mode_reg) col_pins = {col_pins[7], col[8], col_pins[6:0]};
    if (stop_mode_reg && kind_reg == VSP_K_SPLIT) col_pins[8] = 1'b0;
  end

  always_comb begin
    state_next     = state_reg;
    kind_next      = kind_reg;
    seq_next       = seq_reg;
    cnt_next       = cnt_reg + 1'b1;
    ref_cnt_next   = ref_cnt_reg;
    ss_left_next   = ss_left_reg;
    ras_next       = ras_reg;
    cas_next       = cas_reg;
    we_next        = we_reg;
    tgn_next       = tgn_reg;
    sfs_next       = sfs_reg;
    ss_next        = ss_reg;
    addr_next      = addr_reg;
    init_done_next = init_done_reg;
    full_done_next = full_done_reg;
    stop_mode_next = stop_mode_reg;
    refuse_set     = 1'b0;
    case (state_reg)
      VSP_ST_IDLE: begin
        cnt_next = '0;
        seq_next = VSP_SEQ_SINGLE;
        if (go) begin
          state_next = VSP_ST_PRE;
          case (go_cmd)
            VSP_CMD_INIT: begin
              state_next   = VSP_ST_PAUSE;
              seq_next     = VSP_SEQ_INIT_REF;
              kind_next    = VSP_K_REF;
              ref_cnt_next = 4'h0;
            end
            VSP_CMD_FULL: kind_next = VSP_K_FULL;
            VSP_CMD_SPLIT: begin
              kind_next = VSP_K_SPLIT;
              if (!full_done_reg) begin
                state_next = VSP_ST_IDLE;
                refuse_set = 1'b1;
              end
            end
            VSP_CMD_SPST: kind_next = VSP_K_SPST;
            VSP_CMD_ORS: kind_next = VSP_K_ORS;
            VSP_CMD_SERIAL: begin
              // Only reachable from idle, so never inside a transfer
              state_next   = VSP_ST_SCH;
              ss_left_next = {1'b0, cfg_reg[`VSP_CFG_SCNT_LSB +: 8]} + 9'd1;
              ss_next      = 1'b1;
            end
            default: begin
              state_next = VSP_ST_IDLE;
              refuse_set = 1'b1;
            end
          endcase
        end
      end
      VSP_ST_PAUSE: begin
        if (cnt_reg == CNT_W'(PAUSE_CYCLES - 1)) begin
          state_next = VSP_ST_PRE;
          cnt_next   = '0;
        end
      end
      VSP_ST_PRE: begin
        if (cnt_reg == CNT_W'(`VSP_T_RP_CYC - 2)) begin
          addr_next = (kind_reg == VSP_K_REF) ? {5'h00, ref_cnt_reg}
                                              : addr_cfg_reg[`VSP_ADDR_ROW_LSB +: 9];
          case (kind_reg)
            VSP_K_FULL: tgn_next = 1'b0;
            VSP_K_SPLIT: begin
              tgn_next = 1'b0;
              sfs_next = 1'b1;
            end
            VSP_K_SPST: begin
              cas_next  = 1'b0;
              we_next   = 1'b0;
              sfs_next  = 1'b1;
              addr_next = {1'b0, plen_code(cfg_reg[`VSP_CFG_PLEN_LSB +: 2]), 4'h0};
            end
            VSP_K_ORS: cas_next = 1'b0;
            default: ;
          endcase
        end
        if (cnt_reg == CNT_W'(`VSP_T_RP_CYC - 1)) begin
          ras_next   = 1'b0;
          state_next = VSP_ST_RAS;
          cnt_next   = '0;
        end
      end
      VSP_ST_RAS: begin
        // Column settles a clock before its strobe falls
        if ((kind_reg == VSP_K_FULL || kind_reg == VSP_K_SPLIT) &&
            cnt_reg == CNT_W'(`VSP_T_RCD_CYC - 2)) begin
          addr_next = col_pins;
        end
        if ((kind_reg == VSP_K_FULL || kind_reg == VSP_K_SPLIT) &&
            cnt_reg == CNT_W'(`VSP_T_RCD_CYC - 1)) begin
          cas_next  = 1'b0;
        end
        if (cnt_reg == CNT_W'(`VSP_T_RAS_CYC - 1)) begin
          ras_next   = 1'b1;
          cas_next   = 1'b1;
          we_next    = 1'b1;
          tgn_next   = 1'b1;
          sfs_next   = 1'b0;
          addr_next  = 9'h000;
          cnt_next   = '0;
          state_next = VSP_ST_IDLE;
          case (kind_reg)
            VSP_K_FULL: full_done_next = 1'b1;
            VSP_K_SPST: stop_mode_next = 1'b1;
            VSP_K_ORS: stop_mode_next = 1'b0;
            default: ;
          endcase
          if (seq_reg == VSP_SEQ_INIT_REF) begin
            state_next   = VSP_ST_PRE;
            ref_cnt_next = ref_cnt_reg + 4'h1;
            if (ref_cnt_reg == 4'(`VSP_INIT_RAS_CYCLES - 1)) begin
              kind_next = VSP_K_FULL;
              seq_next  = VSP_SEQ_INIT_XFER;
            end
          end else if (seq_reg == VSP_SEQ_INIT_XFER) begin
            state_next   = VSP_ST_SCH;
            seq_next     = VSP_SEQ_INIT_SS;
            ss_left_next = 9'(`VSP_INIT_SS_CYCLES);
            ss_next      = 1'b1;
          end
        end
      end
      VSP_ST_SCH: begin
        if (cnt_reg == CNT_W'(`VSP_T_SS_HALF_CYC - 1)) begin
          ss_next    = 1'b0;
          state_next = VSP_ST_SCL;
          cnt_next   = '0;
        end
      end
      VSP_ST_SCL: begin
        if (cnt_reg == CNT_W'(`VSP_T_SS_HALF_CYC - 1)) begin
          cnt_next     = '0;
          ss_left_next = ss_left_reg - 9'd1;
          if (ss_left_reg == 9'd1) begin
            state_next = VSP_ST_IDLE;
            if (seq_reg == VSP_SEQ_INIT_SS) begin
              init_done_next = 1'b1;
              seq_next       = VSP_SEQ_SINGLE;
              if (auto_sp_reg) begin
                kind_next  = VSP_K_SPST;
                state_next = VSP_ST_PRE;
              end
            end
          end else begin
            ss_next    = 1'b1;
            state_next = VSP_ST_SCH;
          end
        end
      end
      default: state_next = VSP_ST_IDLE;
    endcase
    // A refusal in the clearing cycle still lands
    refused_next = refuse_set | (refused_reg & ~refuse_clr);
    if (go && busy) refused_next = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= VSP_ST_IDLE;
      kind_reg      <= VSP_K_REF;
      seq_reg       <= VSP_SEQ_SINGLE;
      cnt_reg       <= '0;
      ref_cnt_reg   <= 4'h0;
      ss_left_reg   <= 9'h000;
      ras_reg       <= 1'b1;
      cas_reg       <= 1'b1;
      we_reg        <= 1'b1;
      tgn_reg       <= 1'b1;
      sfs_reg       <= 1'b0;
      ss_reg        <= 1'b0;
      addr_reg      <= 9'h000;
      init_done_reg <= 1'b0;
      full_done_reg <= 1'b0;
      stop_mode_reg <= 1'b0;
      refused_reg   <= 1'b0;
    end else if (ce) begin
      state_reg     <= state_next;
      kind_reg      <= kind_next;
      seq_reg       <= seq_next;
      cnt_reg       <= cnt_next;
      ref_cnt_reg   <= ref_cnt_next;
      ss_left_reg   <= ss_left_next;
      ras_reg       <= ras_next;
      cas_reg       <= cas_next;
      we_reg        <= we_next;
      tgn_reg       <= tgn_next;
      sfs_reg       <= sfs_next;
      ss_reg        <= ss_next;
      addr_reg      <= addr_next;
      init_done_reg <= init_done_next;
      full_done_reg <= full_done_next;
      stop_mode_reg <= stop_mode_next;
      refused_reg   <= refused_next;
    end
  end

  assign ras_n                   = ras_reg;
  assign cas_n                   = cas_reg;
  assign write_enable_n          = we_reg;
  assign transfer_gate_n         = tgn_reg;
  assign special_function_select = sfs_reg;
  assign addr                    = addr_reg;
  assign serial_shift_strobe     = ss_reg;
endmodule

// >>> vsp_ctrl_chk.sv
`timescale 1ns/1ns
module vsp_ctrl_chk #(
  parameter int PAUSE_CYCLES = 50000
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       write_enable_n,
  input wire logic       transfer_gate_n,
  input wire logic       special_function_select,
  input wire logic [8:0] addr,
  input wire logic       serial_shift_strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] up_reg, up_next;
  logic [3:0]  nras_reg, nras_next;
  logic        full_reg, full_next, stop_reg, stop_next, rasd_reg, fall;
  // ==========
  // History of the pins
  assign fall = rasd_reg & ~ras_n;
  always_comb begin
    up_next   = (up_reg == PAUSE_CYCLES) ? up_reg : up_reg + 32'h1;
    nras_next = (fall && nras_reg != 4'h8) ? nras_reg + 4'h1 : nras_reg;
    full_next = full_reg | (fall & ~transfer_gate_n & ~special_function_select);
    stop_next = (fall && !cas_n) ? !write_enable_n : stop_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_reg   <= 32'h0;
      nras_reg <= 4'h0;
      full_reg <= 1'b0;
      stop_reg <= 1'b0;
      rasd_reg <= 1'b1;
    end else begin
      up_reg   <= up_next;
      nras_reg <= nras_next;
      full_reg <= full_next;
      stop_reg <= stop_next;
      rasd_reg <= ras_n;
    end
  end
  // ==========
  // Properties
  pause_first_a: assert property (fall |-> up_reg == PAUSE_CYCLES)
    else $error("row strobe before power-up pause");
  eight_ref_a: assert property (fall && !transfer_gate_n |-> nras_reg == 4'h8)
    else $error("transfer before eight row cycles");
  split_order_a: assert property (fall && !transfer_gate_n && special_function_select |-> full_reg)
    else $error("split transfer before full transfer");
  serial_init_a: assert property ($rose(serial_shift_strobe) |-> full_reg)
    else $error("serial clock before full transfer");
  no_overlap_a: assert property (!ras_n |-> !serial_shift_strobe)
    else $error("serial clock inside a memory cycle");
  stop_set_a: assert property (fall && !cas_n && !write_enable_n |->
    special_function_select && transfer_gate_n && addr[3:0] == 4'h0)
    else $error("bad stop-point set cycle");
  plen_code_a: assert property (fall && !cas_n && !write_enable_n |->
    addr[7:4] inside {4'h0, 4'h1, 4'h3, 4'h7} && !addr[8])
    else $error("bad partition length code");
  opt_reset_a: assert property (fall && !cas_n && write_enable_n |->
    !special_function_select && transfer_gate_n)
    else $error("bad option-reset cycle");
  split_col_a: assert property ($fell(cas_n) && !ras_n && !transfer_gate_n &&
    special_function_select |-> !(stop_reg ? addr[8] : addr[7]))
    else $error("split column half bit not zero");
  tap_delay_a: assert property (fall && !transfer_gate_n |-> cas_n[*5] ##1 !cas_n)
    else $error("tap column strobe misplaced");
  cover property (fall && !cas_n && !write_enable_n);
  cover property (fall && !transfer_gate_n && special_function_select && stop_reg);
  cover property ($rose(serial_shift_strobe) && stop_reg);
endmodule
bind vsp_ctrl vsp_ctrl_chk #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_vsp_ctrl_chk (.aclk, .aresetn,
  .ras_n, .cas_n, .write_enable_n, .transfer_gate_n, .special_function_select, .addr,
  .serial_shift_strobe);

// >>> vsp_dev_model.sv
`timescale 1ns/1ns
module vsp_dev_model (
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       write_enable_n,
  input wire logic       transfer_gate_n,
  input wire logic       special_function_select,
  input wire logic [8:0] addr,
  input wire logic       serial_shift_strobe,
  output logic           half_select_flag
);
  logic [7:0] ptr_reg, pend_reg, mask;
  logic [8:0] col;
  logic [3:0] plen_reg;
  logic       xfer, split, pendv_reg;
  logic       stop_reg = 1'b0;
  // ==========
  // Strobe decode; pointer stays unknown until the first full transfer
  always @(negedge ras_n) begin
    xfer  = !transfer_gate_n;
    split = special_function_select;
    if (!cas_n && !write_enable_n && split) begin
      stop_reg = 1'b1;
      plen_reg = addr[7:4];
    end else if (!cas_n) begin
      stop_reg = 1'b0;
    end
  end
  always @(negedge cas_n) begin
    if (!ras_n && xfer) begin
      col = stop_reg ? {addr[7], addr[8], addr[6:0]} : addr;
      if (!split) begin
        ptr_reg   = col[7:0];
        pendv_reg = 1'b0;
      end else begin
        pend_reg  = {~ptr_reg[7], col[6:0]};
        pendv_reg = 1'b1;
      end
    end
  end
  // ==========
  // Serial pointer
  assign mask = stop_reg ? {plen_reg[2:0], 4'hf} : 8'h7f;
  always @(posedge serial_shift_strobe) begin
    if (pendv_reg && (ptr_reg & mask) == mask) begin
      ptr_reg   = pend_reg;
      pendv_reg = 1'b0;
    end else begin
      ptr_reg = ptr_reg + 8'h01;
    end
  end
  assign half_select_flag = ptr_reg[7];
endmodule

// >>> test_vram_serial_pointer_stop_point.sv
`timescale 1ns/1ns
`include "vsp_consts.svh"
module test_vram_serial_pointer_stop_point;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        ras_n, cas_n, we_n, tg_n, sfs, strobe, flag;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, br, rr;
  logic [8:0]  pins;
  int          fails, checks_done, cyc;
  vsp_ctrl #(.PAUSE_CYCLES(20)) u_vsp_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ras_n(ras_n), .cas_n(cas_n), .write_enable_n(we_n), .transfer_gate_n(tg_n),
    .special_function_select(sfs), .addr(pins), .serial_shift_strobe(strobe),
    .half_select_flag(flag));
  vsp_dev_model u_vsp_dev_model (.ras_n(ras_n), .cas_n(cas_n), .write_enable_n(we_n),
    .transfer_gate_n(tg_n), .special_function_select(sfs), .addr(pins),
    .serial_shift_strobe(strobe), .half_select_flag(flag));
  // ==========
  // Bus tasks
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= o;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    br = bresp;
  endtask
  task automatic rd(input logic [7:0] o);
    @(posedge aclk);
    araddr  <= o;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    rr = rresp;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st(input logic [5:0] e, input logic [5:0] m);
    rd(`VSP_OFS_STATUS);
    chk("status", e, v[5:0] & m);
  endtask
  // Busy polling is bounded only by the cycle ceiling
  task automatic go(input logic [2:0] c);
    wr(`VSP_OFS_CTRL, {28'h0, c, 1'b1});
    do rd(`VSP_OFS_STATUS); while (v[0] !== 1'b0);
  endtask
  task automatic xs(input logic [7:0] o, input logic [31:0] d, input logic [2:0] c,
                    input logic [7:0] p, input logic [5:0] s);
    wr(o, d);
    go(c);
    chk("pointer", p, u_vsp_dev_model.ptr_reg);
    st(s, 6'h3f);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Clock, ceiling and sequence
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`VSP_OFS_CFG);
    chk("cfg reset", 32'h0303, v);
    rd(8'h10);
    chk("unmapped read", 32'h2, rr);
    wr(8'h10, 32'h0);
    chk("unmapped write", 32'h2, br);
    go(3'h2);
    st(6'h20, 6'h20);
    wr(`VSP_OFS_STATUS, 32'h20);
    st(6'h00, 6'h20);
    xs(`VSP_OFS_ADDR, 32'h00fe0005, 3'h0, 8'h00, 6'h06);
    xs(`VSP_OFS_ADDR, 32'h007e0005, 3'h1, 8'h7e, 6'h06);
    xs(`VSP_OFS_CFG, 32'h0103, 3'h5, 8'h80, 6'h16);
    xs(`VSP_OFS_ADDR, 32'h00050005, 3'h2, 8'h80, 6'h16);
    xs(`VSP_OFS_CFG, 32'h7f03, 3'h5, 8'h05, 6'h06);
    xs(`VSP_OFS_CFG, 32'h7a03, 3'h5, 8'h80, 6'h16);
    for (int p = 3; p >= 0; p--) begin
      xs(`VSP_OFS_CFG, 32'(p), 3'h3, 8'h80, 6'h1e);
      chk("partition", 32'h7 >> (3 - p), u_vsp_dev_model.plen_reg);
    end
    xs(`VSP_OFS_ADDR, 32'h01030005, 3'h2, 8'h80, 6'h1e);
    xs(`VSP_OFS_CFG, 32'h0f00, 3'h5, 8'h03, 6'h0e);
    xs(`VSP_OFS_ADDR, 32'h00f30005, 3'h1, 8'hf3, 6'h1e);
    xs(`VSP_OFS_ADDR, 32'h00f30005, 3'h4, 8'hf3, 6'h16);
    wr(`VSP_OFS_CTRL, 32'h3);
    go(3'h1);
    st(6'h20, 6'h21);
    // Mid-run reset, then init with the automatic stop-point set
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st(6'h00, 6'h2f);
    wr(`VSP_OFS_CTRL, 32'h11);
    do rd(`VSP_OFS_STATUS); while (v[0] !== 1'b0);
    chk("pointer", 8'h02, u_vsp_dev_model.ptr_reg);
    st(6'h0e, 6'h3f);
    chk("partition", 32'h7, u_vsp_dev_model.plen_reg);
    end_of_test;
  end
endmodule
